// File: logic/sleep_ctrl_params.svh
// Register map, field positions, reset values and timing counts of the power controller
`ifndef SLEEP_CTRL_PARAMS_SVH
`define SLEEP_CTRL_PARAMS_SVH

// Register indices; the byte address on the bus is four times the index
`define REG_IDX_GATES    10'h000
`define REG_IDX_PWR_CTRL 10'h035
`define REG_IDX_DIDR     10'h010
`define REG_IDX_STATUS   10'h011

`define RST_GATES        8'h00
`define RST_PWR_CTRL     8'h00
`define RST_DIDR         8'h00

`define BIT_DS           7
`define BIT_PUD          6
`define BIT_SE           5
`define BIT_SM_HI        4
`define BIT_SM_LO        3
`define BIT_DSE          2
`define BIT_T1           3
`define BIT_T0           2
`define BIT_USI          1
`define BIT_ADC          0
`define GATES_WR_MASK    8'h0f

`define DS_WINDOW_CYC    4
`define DS_ACTIVE_DLY    3
`define DS_HOLD_CYC      3
`define WAKE_HALT_CYC    4
`define SLEEP_ST_DLY     1

`endif

// File: logic/sleep_ctrl_pkg.sv
// Types shared by the power controller files
package sleep_ctrl_pkg;

  typedef enum logic [1:0] {
    MODE_IDLE,
    MODE_NOISE_RED,
    MODE_POWER_DOWN,
    MODE_RESERVED
  } sleep_mode_e;

  typedef enum {
    ST_RUN,
    ST_SLEEP,
    ST_WAKE_HALT
  } core_state_e;

  typedef struct packed {
    logic timer1_gate;
    logic timer0_gate;
    logic serial_unit_gate;
    logic converter_gate;
  } gates_s;

  typedef struct packed {
    logic clk_cpu_run;
    logic clk_io_run;
    logic clk_adc_run;
    logic detector_off;
    logic input_buf_off;
  } sleep_out_s;

  typedef struct packed {
    logic        sel;
    logic        write;
    logic [11:0] addr;
  } ahb_req_s;

endpackage

// File: logic/detector_sleep_seq.sv
// Timed write sequence for the detector-sleep bit
`include "sleep_ctrl_params.svh"
module detector_sleep_seq (
  input  wire logic hclk,
  input  wire logic hresetn,
  input  wire logic wr_stb,
  input  wire logic wr_ds,
  input  wire logic wr_dse,
  output logic      ds_bit,
  output logic      dse_bit,
  output logic      ds_active
);

  logic [2:0] win_q;
  logic [2:0] act_q;
  logic [2:0] hold_q;

  // ----------------------------------------
  // Arming window
  // ----------------------------------------
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      win_q <= 3'h0;
    end else if (wr_stb && wr_ds && wr_dse) begin
      win_q <= 3'(`DS_WINDOW_CYC);
    end else if (wr_stb) begin
      win_q <= 3'h0;
    end else if (win_q != 3'h0) begin
      win_q <= win_q - 3'h1;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      dse_bit <= 1'b0;
    end else if (wr_stb) begin
      dse_bit <= wr_dse && (win_q == 3'h0);
    end else if (win_q == 3'h1) begin
      dse_bit <= 1'b0;
    end
  end

  // ----------------------------------------
  // Set, delayed activation, self clear
  // ----------------------------------------
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ds_bit <= 1'b0;
      act_q  <= 3'h0;
      hold_q <= 3'h0;
    end else if (wr_stb && wr_ds && !wr_dse && win_q != 3'h0) begin
      ds_bit <= 1'b1;
      act_q  <= 3'(`DS_ACTIVE_DLY);
      hold_q <= 3'(`DS_HOLD_CYC);
    end else if (act_q != 3'h0) begin
      act_q <= act_q - 3'h1;
    end else if (hold_q != 3'h0) begin
      hold_q <= hold_q - 3'h1;
      if (hold_q == 3'h1) begin
        ds_bit <= 1'b0;
      end
    end
  end

  assign ds_active = ds_bit && (act_q == 3'h0);

endmodule

// File: logic/sleep_power_ctrl.sv
// Sleep and power reduction controller with AHB-Lite register slave
`include "sleep_ctrl_params.svh"
module sleep_power_ctrl #(
  parameter int NUM_PINS = 16
) (
  input  wire logic                 hclk,
  input  wire logic                 hresetn,
  input  wire logic                 hsel,
  input  wire logic [11:0]          haddr,
  input  wire logic [1:0]           htrans,
  input  wire logic                 hwrite,
  input  wire logic [2:0]           hsize,
  input  wire logic [31:0]          hwdata,
  input  wire logic                 hready,
  output logic      [31:0]          hrdata,
  output logic                      hreadyout,
  output logic                      hresp,
  input  wire logic                 sleep_instr,
  input  wire logic                 wake_irq,
  input  wire logic [2:0]           prep_read_en,
  input  wire logic                 detector_en,
  input  wire logic                 comparator_ref_req,
  input  wire logic                 converter_ref_req,
  input  wire logic                 watchdog_en,
  input  wire logic [NUM_PINS-1:0]  wake_pin_mask,
  output logic                      vref_on,
  output logic                      watchdog_run,
  output logic                      detector_on,
  output logic [NUM_PINS-1:0]       input_buf_en,
  output logic                      pullup_disable,
  output logic [1:0]                int_sense,
  output sleep_ctrl_pkg::gates_s    gates,
  output logic                      comp_mux_allow,
  output sleep_ctrl_pkg::sleep_out_s sleep_out,
  output logic                      cpu_halt,
  output logic                      sleep_nop
);

  // ----------------------------------------
  // Bus address phase capture
  // ----------------------------------------
  sleep_ctrl_pkg::ahb_req_s req_q;
  logic                      ap_valid;

  assign ap_valid  = hsel && hready && htrans[1];
  assign hreadyout = 1'b1;
  assign hresp     = 1'b0;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      req_q <= '0;
    end else if (hready) begin
      req_q.sel   <= ap_valid;
      req_q.write <= hwrite;
      req_q.addr  <= {haddr[11:2], 2'b00};
    end
  end

  // Compares the word index of an aligned byte address with a register index
  function automatic logic hit(input logic [11:0] a, input logic [9:0] idx);
    hit = (a[11:2] == idx);
  endfunction

  logic wr_ctrl;
  logic wr_gates;
  logic wr_didr;

  assign wr_ctrl  = req_q.sel && req_q.write && hit(req_q.addr, `REG_IDX_PWR_CTRL);
  assign wr_gates = req_q.sel && req_q.write && hit(req_q.addr, `REG_IDX_GATES);
  assign wr_didr  = req_q.sel && req_q.write && hit(req_q.addr, `REG_IDX_DIDR);

  // ----------------------------------------
  // Power control register
  // ----------------------------------------
  logic [7:0] ctrl_q;
  logic       ds_bit;
  logic       dse_bit;
  logic       ds_active;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ctrl_q <= `RST_PWR_CTRL;
    end else if (wr_ctrl) begin
      ctrl_q <= hwdata[7:0];
    end
  end

  detector_sleep_seq u_ds (
    .hclk      (hclk),
    .hresetn   (hresetn),
    .wr_stb    (wr_ctrl),
    .wr_ds     (hwdata[`BIT_DS]),
    .wr_dse    (hwdata[`BIT_DSE]),
    .ds_bit    (ds_bit),
    .dse_bit   (dse_bit),
    .ds_active (ds_active)
  );

  sleep_ctrl_pkg::sleep_mode_e mode;
  logic                        sleep_en;

  assign mode           = sleep_ctrl_pkg::sleep_mode_e'(ctrl_q[`BIT_SM_HI:`BIT_SM_LO]);
  assign sleep_en       = ctrl_q[`BIT_SE];
  assign pullup_disable = ctrl_q[`BIT_PUD];
  assign int_sense      = ctrl_q[1:0];

  // ----------------------------------------
  // Power reduction and input disable
  // ----------------------------------------
  logic [3:0]          gates_q;
  logic [NUM_PINS-1:0] didr_q;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      gates_q <= 4'h0;
    end else if (wr_gates) begin
      gates_q <= hwdata[3:0] & 4'(`GATES_WR_MASK);
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      didr_q <= '0;
    end else if (wr_didr) begin
      didr_q <= hwdata[NUM_PINS-1:0];
    end
  end

  // Gates stop clocks, and the converter gate also blocks comparator mux access; peripheral state is held by the peripheral itself
  assign gates.timer1_gate      = gates_q[`BIT_T1];
  assign gates.timer0_gate      = gates_q[`BIT_T0];
  assign gates.serial_unit_gate = gates_q[`BIT_USI];
  assign gates.converter_gate   = gates_q[`BIT_ADC];
  assign comp_mux_allow         = !gates_q[`BIT_ADC];

  // ----------------------------------------
  // Sleep sequencing
  // ----------------------------------------
  sleep_ctrl_pkg::core_state_e state_q;
  logic [2:0]                  halt_q;
  logic                        bod_off_q;
  sleep_ctrl_pkg::sleep_mode_e smode_q;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      state_q   <= sleep_ctrl_pkg::ST_RUN;
      halt_q    <= 3'h0;
      bod_off_q <= 1'b0;
      smode_q   <= sleep_ctrl_pkg::MODE_IDLE;
    end else begin
      case (state_q)
        sleep_ctrl_pkg::ST_RUN: begin
          if (sleep_instr && sleep_en && mode != sleep_ctrl_pkg::MODE_RESERVED) begin
            state_q   <= sleep_ctrl_pkg::ST_SLEEP;
            smode_q   <= mode;
            bod_off_q <= ds_active;
          end
        end
        sleep_ctrl_pkg::ST_SLEEP: begin
          if (wake_irq) begin
            state_q   <= sleep_ctrl_pkg::ST_WAKE_HALT;
            halt_q    <= 3'(`WAKE_HALT_CYC);
            bod_off_q <= 1'b0;
          end
        end
        sleep_ctrl_pkg::ST_WAKE_HALT: begin
          halt_q <= halt_q - 3'h1;
          if (halt_q == 3'h1) begin
            state_q <= sleep_ctrl_pkg::ST_RUN;
          end
        end
        default: begin
          state_q <= sleep_ctrl_pkg::ST_RUN;
        end
      endcase
    end
  end

  logic asleep;
  logic io_stop;
  logic adc_stop;

  assign asleep    = (state_q == sleep_ctrl_pkg::ST_SLEEP);
  assign io_stop   = asleep && smode_q != sleep_ctrl_pkg::MODE_IDLE;
  assign adc_stop  = asleep && smode_q == sleep_ctrl_pkg::MODE_POWER_DOWN;
  assign cpu_halt  = state_q != sleep_ctrl_pkg::ST_RUN;
  assign sleep_nop = (state_q == sleep_ctrl_pkg::ST_RUN) && sleep_instr && !sleep_en;

  assign sleep_out.clk_cpu_run   = !cpu_halt;
  assign sleep_out.clk_io_run    = !io_stop;
  assign sleep_out.clk_adc_run   = !adc_stop;
  assign sleep_out.detector_off  = asleep && bod_off_q;
  assign sleep_out.input_buf_off = io_stop && adc_stop;

  assign detector_on  = detector_en && !(asleep && bod_off_q);
  assign vref_on      = detector_on || comparator_ref_req || converter_ref_req;
  assign watchdog_run = watchdog_en;

  // Buffers: analog disable always wins; deep sleep keeps only wake pins
  always_comb begin
    for (int i = 0; i < NUM_PINS; i++) begin
      input_buf_en[i] = !didr_q[i] && (!(io_stop && adc_stop) || wake_pin_mask[i]);
    end
  end

  // ----------------------------------------
  // Read data
  // ----------------------------------------
  logic [7:0] ctrl_rd;

  assign ctrl_rd = {ds_bit, ctrl_q[6:3], dse_bit, ctrl_q[1:0]};

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hrdata <= 32'h0;
    end else if (ap_valid && !hwrite) begin
      case (haddr[11:2])
        `REG_IDX_PWR_CTRL: hrdata <= {24'h0, ctrl_rd};
        `REG_IDX_GATES:    hrdata <= {24'h0, prep_read_en, 1'b0, gates_q};
        `REG_IDX_DIDR:     hrdata <= {{(32-NUM_PINS){1'b0}}, didr_q};
        `REG_IDX_STATUS:   hrdata <= {26'h0, ds_active, asleep, bod_off_q, vref_on, 2'(state_q)};
        default:           hrdata <= 32'h0;
      endcase
    end
  end

endmodule

// File: tb/sleep_power_ctrl_checker.sv
// Concurrent checks on the ports of the sleep and power reduction controller
module sleep_power_ctrl_checker #(
  parameter int NUM_PINS = 16
) (
  input wire logic                       hclk,
  input wire logic                       hresetn,
  input wire logic                       hreadyout,
  input wire logic                       hresp,
  input wire logic                       sleep_instr,
  input wire logic                       detector_en,
  input wire logic                       comparator_ref_req,
  input wire logic                       converter_ref_req,
  input wire logic                       watchdog_en,
  input wire logic [NUM_PINS-1:0]        wake_pin_mask,
  input wire logic                       vref_on,
  input wire logic                       watchdog_run,
  input wire logic                       detector_on,
  input wire logic [NUM_PINS-1:0]        input_buf_en,
  input wire sleep_ctrl_pkg::gates_s     gates,
  input wire logic                       comp_mux_allow,
  input wire sleep_ctrl_pkg::sleep_out_s sleep_out,
  input wire logic                       cpu_halt,
  input wire logic                       sleep_nop
);
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);

  AST_VREF: assert property (vref_on == (detector_on | comparator_ref_req | converter_ref_req))
    else $error("reference enable does not follow requests");
  AST_WDOG: assert property (watchdog_run == watchdog_en)
    else $error("watchdog gated");
  AST_DEEP_BUF: assert property (!sleep_out.clk_io_run && !sleep_out.clk_adc_run |-> (input_buf_en & ~wake_pin_mask) == '0)
    else $error("input buffer on in deep sleep");
  AST_MUX: assert property (comp_mux_allow == !gates.converter_gate)
    else $error("comparator mux access wrong");
  AST_NOP: assert property (sleep_nop |-> sleep_instr && !cpu_halt ##1 !cpu_halt)
    else $error("sleep without enable halted");
  AST_ENTRY: assert property ($rose(cpu_halt) |-> $past(sleep_instr))
    else $error("halt without sleep");
  AST_WAKE: assert property ($fell(cpu_halt) |-> $past(cpu_halt, 4))
    else $error("wake halt too short");
  AST_DET: assert property (!cpu_halt |-> detector_on == detector_en)
    else $error("detector off while running");
  AST_BUS: assert property (hreadyout && !hresp)
    else $error("bus wait or error");

  cover property ($rose(cpu_halt));
  cover property (sleep_nop);
  cover property (cpu_halt && detector_en && !detector_on);
endmodule

bind sleep_power_ctrl sleep_power_ctrl_checker #(.NUM_PINS(NUM_PINS)) u_chk (.hclk, .hresetn, .hreadyout,
  .hresp, .sleep_instr, .detector_en, .comparator_ref_req, .converter_ref_req, .watchdog_en, .wake_pin_mask,
  .vref_on, .watchdog_run, .detector_on, .input_buf_en, .gates, .comp_mux_allow, .sleep_out, .cpu_halt,
  .sleep_nop);

// File: tb/sleep_power_ctrl_tb.sv
// Self-checking bench for the sleep and power reduction controller
module sleep_power_ctrl_tb;
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [11:0] IDX_GATES = 12'h000;
  localparam logic [11:0] IDX_CTRL  = 12'h035;
  localparam logic [11:0] IDX_DIDR  = 12'h010;
  logic hclk, hresetn, hsel, hwrite, hready, hreadyout, hresp, sleep_instr, wake_irq;
  logic detector_en, comparator_ref_req, converter_ref_req, watchdog_en;
  logic vref_on, watchdog_run, detector_on, pullup_disable, comp_mux_allow, cpu_halt, sleep_nop;
  logic [11:0] haddr;
  logic [1:0]  htrans, int_sense;
  logic [2:0]  hsize, prep_read_en;
  logic [31:0] hwdata, hrdata, rd;
  logic [15:0] wake_pin_mask, input_buf_en;
  sleep_ctrl_pkg::gates_s     gates;
  sleep_ctrl_pkg::sleep_out_s sleep_out;
  int failures, n_tests;
  assign hready = hreadyout;

  sleep_power_ctrl u_dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready), .hrdata(hrdata),
    .hreadyout(hreadyout), .hresp(hresp), .sleep_instr(sleep_instr), .wake_irq(wake_irq),
    .prep_read_en(prep_read_en), .detector_en(detector_en), .comparator_ref_req(comparator_ref_req),
    .converter_ref_req(converter_ref_req), .watchdog_en(watchdog_en), .wake_pin_mask(wake_pin_mask),
    .vref_on(vref_on), .watchdog_run(watchdog_run), .detector_on(detector_on), .input_buf_en(input_buf_en),
    .pullup_disable(pullup_disable), .int_sense(int_sense), .gates(gates), .comp_mux_allow(comp_mux_allow),
    .sleep_out(sleep_out), .cpu_halt(cpu_halt), .sleep_nop(sleep_nop));

  // ----------------------------------------
  // Bus and compare helpers
  // ----------------------------------------
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      failures++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic bus(input logic w, input logic [11:0] idx, input logic [31:0] wd);
    hsel <= 1'b1; haddr <= {idx[9:0], 2'b00}; htrans <= 2'h2; hwrite <= w; hsize <= 3'h2;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    hsel <= 1'b0; htrans <= 2'h0; hwdata <= wd;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    rd = hrdata;
  endtask

  task automatic wr(input logic [11:0] idx, input logic [31:0] d);
    bus(1'b1, idx, d);
  endtask

  task automatic rchk(input logic [11:0] idx, input logic [31:0] exp);
    bus(1'b0, idx, 32'h0);
    chk(rd, exp);
  endtask

  // Pulses the sleep line once, checks the clocks, then wakes the core
  task automatic nap(input logic [1:0] m, input logic det_exp);
    int n;
    sleep_instr <= 1'b1;
    @(posedge hclk);
    sleep_instr <= 1'b0;
    repeat (2) @(posedge hclk);
    chk(cpu_halt, 1'b1);
    chk({sleep_out.clk_cpu_run, sleep_out.clk_io_run, sleep_out.clk_adc_run}, {1'b0, m == 2'h0, m != 2'h2});
    chk(input_buf_en, (m == 2'h2) ? 16'h0ff0 : 16'hfff0);
    chk({detector_on, watchdog_run}, {det_exp, 1'b1});
    chk({sleep_out.detector_off, sleep_out.input_buf_off}, {!det_exp, m == 2'h2});
    wake_irq <= 1'b1;
    n = 0;
    do @(posedge hclk); while (cpu_halt !== 1'b0 && ++n < 30);
    wake_irq <= 1'b0;
    chk(n >= 4 && n < 30, 1'b1);
  endtask

  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  task automatic t_regs();
    rchk(IDX_GATES, 32'ha0);
    rchk(IDX_CTRL, 32'h0);
    wr(IDX_GATES, 32'hff);
    rchk(IDX_GATES, 32'haf);
    chk({gates, comp_mux_allow}, 5'h1e);
    wr(IDX_GATES, 32'h0);
    @(posedge hclk);
    chk({gates, comp_mux_allow}, 5'h01);
    wr(IDX_CTRL, 32'h5b);
    rchk(IDX_CTRL, 32'h5b);
    chk({pullup_disable, int_sense}, 3'h7);
    rchk(12'h3f0, 32'h0);
    wr(IDX_DIDR, 32'h000f);
    @(posedge hclk);
    chk(input_buf_en, 16'hfff0);
  endtask

  task automatic t_modes();
    for (int m = 0; m < 3; m++) begin
      wr(IDX_CTRL, {24'h0, 3'b001, m[1:0], 3'b000});
      nap(m[1:0], 1'b1);
    end
    // Reserved mode with sleep enabled: no sleep and no no-operation pulse
    wr(IDX_CTRL, 32'h38);
    sleep_instr <= 1'b1;
    @(posedge hclk);
    chk(sleep_nop, 1'b0);
    sleep_instr <= 1'b0;
    @(posedge hclk);
    chk(cpu_halt, 1'b0);
    wr(IDX_CTRL, 32'h10);
    sleep_instr <= 1'b1;
    @(posedge hclk);
    chk(sleep_nop, 1'b1);
    sleep_instr <= 1'b0;
    @(posedge hclk);
    chk(cpu_halt, 1'b0);
  endtask

  task automatic t_detector_sleep();
    wr(IDX_CTRL, 32'h30);
    wr(IDX_CTRL, 32'hb4);
    wr(IDX_CTRL, 32'hb0);
    repeat (3) @(posedge hclk);
    nap(2'h2, 1'b0);
    chk(detector_on, 1'b1);
    rchk(IDX_CTRL, 32'h30);
    {comparator_ref_req, detector_en} <= 2'b10;
    @(posedge hclk);
    #1 chk(vref_on, 1'b1);
    comparator_ref_req <= 1'b0;
    @(posedge hclk);
    #1 chk(vref_on, 1'b0);
    {converter_ref_req, watchdog_en} <= 2'b10;
    @(posedge hclk);
    #1 chk({vref_on, watchdog_run}, 2'b10);
  endtask

  task automatic end_of_test();
    $display("comparisons %0d, mismatches %0d", n_tests, failures);
    if (failures == 0 && n_tests > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask

  initial begin
    hclk = 1'b0;
    forever #2 hclk = ~hclk;
  end

  initial begin
    #40000;
    failures++;
    end_of_test();
  end

  initial begin
    {hresetn, hsel, hwrite, sleep_instr, wake_irq, comparator_ref_req, converter_ref_req} = '0;
    {haddr, htrans, hsize, hwdata} = '0;
    {detector_en, watchdog_en} = 2'b11;
    prep_read_en = 3'h5;
    wake_pin_mask = 16'h0ff0;
    repeat (8) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    t_regs();
    t_modes();
    t_detector_sleep();
    end_of_test();
  end
endmodule
